// >>> rtl/cevc_core_event_stage.sv
// core event stage: prioritised, nesting event controller
`timescale 1ns/100ps
module cevc_core_event_stage (
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    input  wire logic                  clk_en,
    input  wire cevc_pkg::cevc_events_t evt_in,
    input  wire logic                  nmi_pin,
    input  wire logic [8:0]            gen_pin,
    input  wire logic [31:0]           cur_pc,
    input  wire logic                  insn_retire,
    input  wire logic                  rte_valid,
    input  wire logic [3:0]            rte_level,
    input  wire logic                  save_done,
    output logic                       take_q,
    output logic [3:0]                 take_level_q,
    output logic                       save_state_q,
    output logic                       flush_insn_q,
    output logic                       emu_mode_q,
    output logic                       sys_reset_q,
    output logic [31:0]                ret_addr_q,
    output logic [3:0]                 cur_level_q
);
    // ======================================
    // pin synchronisers
    logic [9:0] pin_s1_q;
    logic [9:0] pin_s2_q;
    logic [9:0] pin_s1_d;
    always_comb begin
        pin_s1_d = {nmi_pin, gen_pin};
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pin_s1_q <= 10'h000;
            pin_s2_q <= 10'h000;
        end else if (clk_en) begin
            pin_s1_q <= pin_s1_d;
            pin_s2_q <= pin_s1_q;
        end
    end

    // lowest set bit wins, matching fixed priority order
    function automatic logic [3:0] top_level(input logic [15:0] v);
        logic [3:0] r;
        r = cevc_pkg::LVL_IDLE;
        for (int i = 15; i >= 0; i--) begin
            if (v[i]) r = 4'(i);
        end
        return r;
    endfunction : top_level

    // ======================================
    // request vector
    logic [15:0] req;
    always_comb begin
        req = 16'h0000;
        req[cevc_pkg::LVL_EMU]    = evt_in.emu;
        req[cevc_pkg::LVL_RESET]  = evt_in.soft_reset;
        req[cevc_pkg::LVL_NMI]    = evt_in.watchdog | pin_s2_q[9];
        req[cevc_pkg::LVL_EXCEPT] = evt_in.misalign | evt_in.undef_insn;
        req[cevc_pkg::LVL_HWERR]  = evt_in.hw_error;
        req[cevc_pkg::LVL_TIMER]  = evt_in.core_timer;
        // routed peripheral requests, pins and software raise
        req[15:7] = evt_in.general | evt_in.soft_raise | pin_s2_q[8:0];
    end

    // ======================================
    // pending, active, return addresses, sequencer
    cevc_pkg::cevc_state_t state_q, state_d;
    logic [15:0] pend_q, pend_d;
    logic [15:0] act_q, act_d;
    logic [31:0] ret_q [16];
    logic [31:0] ret_d [16];
    logic        take_d, save_d, flush_d, emu_d, rst_d;
    logic [3:0]  lvl_d, cur_d, win;
    logic [31:0] ra_d;
    logic [15:0] clr;
    logic [4:0]  act_top;

    always_comb begin
        state_d = state_q;
        act_d   = act_q;
        ret_d   = ret_q;
        take_d  = 1'b0;
        save_d  = save_state_q;
        flush_d = 1'b0;
        emu_d   = emu_mode_q;
        rst_d   = 1'b0;
        lvl_d   = take_level_q;
        ra_d    = ret_addr_q;
        clr     = 16'h0000;
        win     = top_level(pend_q);
        // fifteen is a real level, so an idle stack must rank below it
        act_top = (|act_q) ? {1'b0, top_level(act_q)} : 5'h10;
        if (rte_valid && act_q[rte_level]) begin
            act_d[rte_level] = 1'b0;
            ra_d = ret_q[rte_level];
            if (rte_level == cevc_pkg::LVL_EMU) emu_d = 1'b0;
        end
        unique case (state_q)
            cevc_pkg::ST_RUN: begin
                // only strictly higher priority than the current level preempts
                if ((|pend_q) && ({1'b0, win} < act_top)) begin
                    lvl_d = win;
                    ret_d[win] = cur_pc;
                    // exception aborts the faulting instruction
                    flush_d = (win == cevc_pkg::LVL_EXCEPT) && !insn_retire;
                    if (win == cevc_pkg::LVL_RESET) begin
                        rst_d = 1'b1;
                        clr   = 16'hffff;
                        act_d = cevc_pkg::ACTIVE_RESET;
                    end else begin
                        save_d  = 1'b1;
                        state_d = cevc_pkg::ST_SAVE;
                    end
                end
            end
            cevc_pkg::ST_SAVE: begin
                // routine starts only after state is on the supervisor stack
                if (save_done) begin
                    save_d  = 1'b0;
                    take_d  = 1'b1;
                    act_d[take_level_q] = 1'b1;
                    clr[take_level_q]   = 1'b1;
                    if (take_level_q == cevc_pkg::LVL_EMU) emu_d = 1'b1;
                    state_d = cevc_pkg::ST_SERV;
                end
            end
            cevc_pkg::ST_SERV: begin
                state_d = cevc_pkg::ST_RUN;
            end
            default: begin
                state_d = cevc_pkg::ST_RUN;
            end
        endcase
        // a new request in the clearing cycle stays pending
        pend_d = (pend_q & ~clr) | req;
        cur_d  = top_level(act_d);
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q      <= cevc_pkg::ST_RUN;
            pend_q       <= cevc_pkg::PEND_RESET;
            act_q        <= cevc_pkg::ACTIVE_RESET;
            for (int i = 0; i < 16; i++) ret_q[i] <= cevc_pkg::ADDR_RESET;
            take_q       <= 1'b0;
            take_level_q <= cevc_pkg::LVL_IDLE;
            save_state_q <= 1'b0;
            flush_insn_q <= 1'b0;
            emu_mode_q   <= 1'b0;
            sys_reset_q  <= 1'b0;
            ret_addr_q   <= cevc_pkg::ADDR_RESET;
            cur_level_q  <= cevc_pkg::LVL_IDLE;
        end else if (clk_en) begin
            state_q      <= state_d;
            pend_q       <= pend_d;
            act_q        <= act_d;
            ret_q        <= ret_d;
            take_q       <= take_d;
            take_level_q <= lvl_d;
            save_state_q <= save_d;
            flush_insn_q <= flush_d;
            emu_mode_q   <= emu_d;
            sys_reset_q  <= rst_d;
            ret_addr_q   <= ra_d;
            cur_level_q  <= cur_d;
        end
    end

    // ======================================
    // checks
    pend_hold_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && req[9] |=> pend_q[9]) else $error("request not latched pending");
    prio_grant_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(save_state_q) |-> take_level_q == top_level($past(pend_q)))
        else $error("lower priority granted first");
    save_first_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
        take_q |-> $past(save_state_q)) else $error("taken without state save");
    reset_evt_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
        sys_reset_q |-> take_level_q == cevc_pkg::LVL_RESET) else $error("bad reset event");
    emu_enter_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && take_q && take_level_q == cevc_pkg::LVL_EMU |=> emu_mode_q)
        else $error("emulation mode not entered");
    nest_act_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
        take_q |-> act_q[take_level_q]) else $error("routine not active");
    nmi_pin_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && pin_s2_q[9] |=> pend_q[cevc_pkg::LVL_NMI]) else $error("nmi pin lost");
    ret_addr_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && rte_valid && act_q[rte_level] && !take_q |=> ret_addr_q == $past(ret_q[rte_level]))
        else $error("wrong return address");
    save_hold_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && save_state_q && !save_done |=> save_state_q) else $error("state save dropped early");
    flush_exc_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
        flush_insn_q |-> take_level_q == cevc_pkg::LVL_EXCEPT) else $error("abort outside exception");
    low_grant_a : assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && state_q == cevc_pkg::ST_RUN && pend_q == 16'h8000 && act_q == 16'h0000
        |=> save_state_q && take_level_q == 4'hf) else $error("lowest level never granted");

    // ======================================
    // main scenarios reached
    cov_gen15_c : cover property (@(posedge ref_clk) take_q && take_level_q == 4'hf);
    cov_nest_c : cover property (@(posedge ref_clk) take_q && act_q[15] && take_level_q < 4'hf);
    cov_exc_c  : cover property (@(posedge ref_clk) flush_insn_q);
    cov_emu_c  : cover property (@(posedge ref_clk) take_q && take_level_q == cevc_pkg::LVL_EMU);
endmodule : cevc_core_event_stage

// >>> rtl/cevc_pkg.sv
// shared constants and types for the core event stage
package cevc_pkg;
    // ======================================
    // event levels, 0 is highest priority
    localparam int unsigned NUM_LEVELS   = 16;
    localparam logic [3:0]  LVL_EMU      = 4'h0;
    localparam logic [3:0]  LVL_RESET    = 4'h1;
    localparam logic [3:0]  LVL_NMI      = 4'h2;
    localparam logic [3:0]  LVL_EXCEPT   = 4'h3;
    localparam logic [3:0]  LVL_RSVD     = 4'h4;
    localparam logic [3:0]  LVL_HWERR    = 4'h5;
    localparam logic [3:0]  LVL_TIMER    = 4'h6;
    localparam logic [3:0]  LVL_GEN_LO   = 4'h7;
    localparam int unsigned NUM_GEN      = 9;
    localparam logic [3:0]  LVL_IDLE     = 4'hf;
    localparam logic [15:0] PEND_RESET   = 16'h0000;
    localparam logic [15:0] ACTIVE_RESET = 16'h0000;
    localparam logic [31:0] ADDR_RESET   = 32'h0000_0000;

    // ======================================
    // raw event inputs grouped by class
    typedef struct packed {
        logic       emu;
        logic       soft_reset;
        logic       watchdog;
        logic       hw_error;
        logic       core_timer;
        logic       misalign;
        logic       undef_insn;
        logic [8:0] general;
        logic [8:0] soft_raise;
    } cevc_events_t;

    // grant to the program sequencer
    typedef struct packed {
        logic        take;
        logic [3:0]  level;
        logic        save_state;
        logic [31:0] ret_addr;
    } cevc_grant_t;

    typedef enum logic [2:0] {
        ST_RUN  = 3'b001,
        ST_SAVE = 3'b010,
        ST_SERV = 3'b100
    } cevc_state_t;
endpackage : cevc_pkg

// >>> sim/cevc_seq_model.sv
// sequencer stand-in: acknowledges each state save after a chosen lag
`timescale 1ns/100ps
module cevc_seq_model (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       save_state_q,
    input  wire logic [2:0] lag,
    output logic            save_done
);
    logic [2:0] cnt_q;
    // ======================================
    // save handshake
    // done is never raised before a save is asked for, so the routine cannot start early
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !save_state_q || save_done) begin
            cnt_q     <= 3'h0;
            save_done <= 1'b0;
        end else if (cnt_q >= lag) begin
            save_done <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 3'h1;
        end
    end
endmodule : cevc_seq_model

// >>> sim/testbench.sv
// self-checking bench for the core event stage
`timescale 1ns/100ps
module testbench;
    logic                   ref_clk = 1'b0, rst_n = 1'b0, nmi_pin = 1'b0, rte_valid = 1'b0;
    logic                   clk_en = 1'b1, insn_retire = 1'b0;
    logic [8:0]             gen_pin = 9'h0;
    logic [31:0]            cur_pc = 32'h0, ret_addr_q;
    logic [3:0]             rte_level = 4'h0, take_level_q, cur_level_q;
    logic [2:0]             lag = 3'h0;
    logic                   save_done, take_q, save_state_q, flush_insn_q, emu_mode_q, sys_reset_q;
    cevc_pkg::cevc_events_t evt_in = '0;
    int                     err_total = 0, checks = 0, flush_cnt = 0, f0 = 0, a, b;
    int                     act[$];
    int                     cls[8] = '{24, 22, 25, 19, 18, 21, 20, 29};
    logic [15:0]            pend = 16'h0;
    logic [31:0]            pcs[16];

    cevc_core_event_stage i_cevc_core_event_stage (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
        .evt_in(evt_in), .nmi_pin(nmi_pin), .gen_pin(gen_pin), .cur_pc(cur_pc), .insn_retire(insn_retire),
        .rte_valid(rte_valid), .rte_level(rte_level), .save_done(save_done), .take_q(take_q),
        .take_level_q(take_level_q), .save_state_q(save_state_q), .flush_insn_q(flush_insn_q),
        .emu_mode_q(emu_mode_q), .sys_reset_q(sys_reset_q), .ret_addr_q(ret_addr_q),
        .cur_level_q(cur_level_q));
    cevc_seq_model i_cevc_seq_model (.ref_clk(ref_clk), .rst_n(rst_n), .save_state_q(save_state_q),
        .lag(lag), .save_done(save_done));

    initial begin
        forever #50 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) if (flush_insn_q === 1'b1) flush_cnt++;

    // ======================================
    // checking and closing
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #10;
    endtask : tick
    task automatic await(ref logic s);
        for (int n = 0; s !== 1'b1; n++) begin
            if (n > 40) begin
                check("handshake wait", 0, 1);
                test_done();
            end
            tick(1);
        end
    endtask : await

    // ======================================
    // reference model: source code to level, pending set, active stack
    // codes 0-8 soft raise, 9-17 general, 18-24 struct classes, 25 nmi pin, 26-34 pins
    function automatic int lvl_of(input int c);
        if (c < 9) return c + 7;
        if (c < 18) return c - 2;
        if (c > 25) return c - 19;
        case (c)
            18, 19:  return 3;
            20:      return 6;
            21:      return 5;
            22, 25:  return 2;
            23:      return 1;
            default: return 0;
        endcase
    endfunction : lvl_of
    task automatic pulse(input int a, input int b = -1);
        logic [24:0] m;
        m = 25'h0;
        cur_pc = $urandom();
        lag = 3'($urandom_range(0, 5));
        f0 = flush_cnt;
        for (int c = 0; c < 35; c++) begin
            if (c == a || c == b) begin
                pend[lvl_of(c)] = 1'b1;
                if (c < 25) m[c] = 1'b1;
            end
        end
        evt_in = m;
        nmi_pin = (a == 25);
        gen_pin = (a > 25) ? 9'h1 << (a - 26) : 9'h0;
        tick(1);
        evt_in = '0;
        nmi_pin = 1'b0;
        gen_pin = 9'h0;
    endtask : pulse
    task automatic serve();
        int e;
        e = 0;
        while (!pend[e] && e < 15) e++;
        await(save_state_q);
        check("grant level", take_level_q, e);
        await(take_q);
        check("active level", cur_level_q, e);
        pend[e] = 1'b0;
        act.push_back(e);
        pcs[e] = cur_pc;
        tick(1);
        check("abort pulse", flush_cnt - f0, e == 3 && !insn_retire);
    endtask : serve
    task automatic rte(input int l);
        rte_valid = 1'b1;
        rte_level = 4'(l);
        tick(1);
        rte_valid = 1'b0;
        act = act.find(x) with (x != l);
        tick(1);
        check("level after return", cur_level_q, act.size() ? act[$] : 15);
        check("return address", ret_addr_q, pcs[l]);
    endtask : rte

    // ======================================
    // main sequence
    initial begin
        void'($urandom(32'h897d));
        tick(20);
        rst_n = 1'b1;
        check("idle level", cur_level_q, 15);
        check("idle address", ret_addr_q, 0);
        check("idle save", save_state_q, 0);
        foreach (cls[i]) begin
            // one exception arrives after its instruction already retired
            insn_retire = (i == 4);
            pulse(cls[i]);
            serve();
            if (i == 0) check("emulation mode", emu_mode_q, 1);
            rte(act[$]);
        end
        check("emulation left", emu_mode_q, 0);
        repeat (6) begin
            a = $urandom_range(0, 8);
            b = 9 + (a + 1 + $urandom_range(0, 7)) % 9;
            pulse(a, b);
            serve();
            tick(3);
            check("lower waits", save_state_q, 0);
            rte(act[$]);
            serve();
            rte(act[$]);
        end
        // software level 14 kept for software, as is expected of it; the code also raises it from general bit 7 and gen_pin bit 7
        pulse(7);
        clk_en = 1'b0;
        tick(5);
        check("frozen save", save_state_q, 0);
        clk_en = 1'b1;
        serve();
        pulse(11);
        serve();
        pulse(19);
        serve();
        pulse(14);
        rte(3);
        rte(9);
        serve();
        rte(12);
        rte(14);
        pulse(17);
        serve();
        pulse(23);
        await(sys_reset_q);
        pend = 16'h0;
        act.delete();
        tick(2);
        check("level after reset", cur_level_q, 15);
        pulse(0);
        serve();
        rst_n = 1'b0;
        tick(2);
        rst_n = 1'b1;
        pend = 16'h0;
        act.delete();
        check("level after pin reset", cur_level_q, 15);
        check("address after pin reset", ret_addr_q, 0);
        test_done();
    end
endmodule : testbench
